/* logic/hbl_host_port.sv */
`timescale 1ns/1ps
`include "hbl_regs.svh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module hbl_host_port
   import hbl_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // Strap pins
   input  wire logic        eeprom_select_strap_i,
   input  wire logic        eeprom_clock_strap_i,
   // Host bus pins
   input  wire logic [5:0]  host_addr_i,
   input  wire logic        host_cs_b_i,
   input  wire logic        host_rd_b_i,
   input  wire logic        host_wr_b_i,
   input  wire logic [15:0] host_data_lines_i,
   output logic      [15:0] host_data_lines_o,
   output logic             host_data_lines_oe_b_o,
   // Packet data window
   output logic             pdw_rd_o,
   output logic             pdw_wr_o,
   output logic      [15:0] pdw_wdata_o,
   input  wire logic [15:0] pdw_rdata_i,
   // Status and reset request
   output hbl_mode_e        bus_mode_o,
   output logic             ctrl_reset_o
);

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   logic [26:0] sync1_r;
   logic [26:0] sync2_r;
   logic        s_sel;
   logic        s_clk;
   logic [5:0]  s_addr;
   logic        s_cs_b;
   logic        s_rd_b;
   logic        s_wr_b;
   logic [15:0] s_data;
   logic        s_rd;
   logic        s_wr;

   // Two stages; the first is read by the second only
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sync1_r <= `HBL_SYNC_IDLE;
         sync2_r <= `HBL_SYNC_IDLE;
      end
      else
      begin
         sync1_r <= {eeprom_select_strap_i, eeprom_clock_strap_i, host_addr_i,
                     host_cs_b_i, host_rd_b_i, host_wr_b_i, host_data_lines_i};
         sync2_r <= sync1_r;
      end
   end

   // Field split in the same order as the capture above
   assign {s_sel, s_clk, s_addr, s_cs_b, s_rd_b, s_wr_b, s_data} = sync2_r;
   assign s_rd = !s_cs_b && !s_rd_b;
   assign s_wr = !s_cs_b && !s_wr_b;

   // -------------------------------------------------------------------
   // Strap capture
   // -------------------------------------------------------------------
   hbl_mode_e  mode_r;
   hbl_mode_e  mode_nxt;
   logic       strap_done_r;
   logic       strap_done_nxt;
   logic [1:0] fill_r;
   logic [1:0] fill_nxt;

   // Decode once the synchronisers hold real pin levels; an earlier
   // capture would see the reset fill and always pick the ISA setting
   always_comb
   begin
      mode_nxt       = mode_r;
      fill_nxt       = {fill_r[0], 1'b1};
      strap_done_nxt = strap_done_r || fill_r[1];
      if (!strap_done_r && fill_r[1])
      begin
         if (s_sel && s_clk)
            mode_nxt = HBL_MODE_MCU;
         else if (s_clk)
            mode_nxt = HBL_MODE_STEER;
         else
            mode_nxt = HBL_MODE_ISA;
      end
   end

   // Setting held until next reset
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mode_r       <= HBL_MODE_ISA;
         strap_done_r <= 1'b0;
         fill_r       <= `HBL_FILL_EMPTY;
      end
      else
      begin
         mode_r       <= mode_nxt;
         strap_done_r <= strap_done_nxt;
         fill_r       <= fill_nxt;
      end
   end

   assign bus_mode_o = mode_r;

   // -------------------------------------------------------------------
   // Access sequencer
   // -------------------------------------------------------------------
   hbl_state_e st_r;
   hbl_state_e st_nxt;
   logic       start_rd;
   logic       start_wr;
   logic       steer;
   logic       in_csr;

   assign steer  = (mode_r == HBL_MODE_STEER);
   assign in_csr = (s_addr <= `HBL_OFS_CSR_LAST)
                   && (s_addr != `HBL_OFS_DATA_WINDOW)
                   && (s_addr != `HBL_OFS_UNUSED);
   assign start_rd = strap_done_r && (st_r == HBL_ST_IDLE) && s_rd;
   assign start_wr = strap_done_r && (st_r == HBL_ST_IDLE) && s_wr && !s_rd;

   // One action per strobe; wait for strobe release
   always_comb
   begin
      case (st_r)
         HBL_ST_IDLE: st_nxt = (start_rd || start_wr) ? HBL_ST_BUSY
                                                      : HBL_ST_IDLE;
         HBL_ST_BUSY: st_nxt = (s_rd || s_wr) ? HBL_ST_BUSY : HBL_ST_IDLE;
         default:     st_nxt = HBL_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         st_r <= HBL_ST_IDLE;
      else
         st_r <= st_nxt;
   end

   // -------------------------------------------------------------------
   // Register file write steering
   // -------------------------------------------------------------------
   logic       wr_en;
   logic [7:0] wr_byte;
   logic [4:0] rd_lo_addr;
   logic [4:0] rd_hi_addr;
   logic [7:0] csr_lo;
   logic [7:0] csr_hi;

   assign wr_en = start_wr && in_csr;
   // Odd steered write uses high lane, all else the low lane
   assign wr_byte = (steer && s_addr[0]) ? s_data[15:8]
                                         : s_data[7:0];

   // Even pair address for steered odd reads; same offset for ISA odd
   assign rd_lo_addr = (s_addr[0] && !steer) ? s_addr[4:0]
                                             : {s_addr[4:1], 1'b0};
   assign rd_hi_addr = {s_addr[4:1], 1'b1};

   hbl_csr_mem u_csr
   (
      .clk_i        (clk_i),
      .rst_b_i      (rst_b_i),
      .wr_en_i      (wr_en),
      .wr_addr_i    (s_addr[4:0]),
      .wr_data_i    (wr_byte),
      .rd_addr_lo_i (rd_lo_addr),
      .rd_addr_hi_i (rd_hi_addr),
      .rd_data_lo_o (csr_lo),
      .rd_data_hi_o (csr_hi)
   );

   // -------------------------------------------------------------------
   // Read lane steering, data window and reset
   // -------------------------------------------------------------------
   logic [5:0]  raddr_r;
   logic [15:0] dout_nxt;
   logic [15:0] dout_r;
   logic        is_win;

   assign is_win = (s_addr == `HBL_OFS_DATA_WINDOW);

   // Remember the read address for the cycle the memory data appears
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         raddr_r <= `HBL_ADDR_ZERO;
      else if (st_r == HBL_ST_IDLE)
         raddr_r <= s_addr;
   end

   always_comb
   begin
      if (raddr_r == `HBL_OFS_DATA_WINDOW)
         dout_nxt = pdw_rdata_i;
      else if (raddr_r == `HBL_OFS_LOW_ONLY)
         dout_nxt = {`HBL_LANE_ZERO, csr_lo};
      else if (raddr_r == `HBL_OFS_UNUSED || raddr_r > `HBL_OFS_CSR_LAST)
         dout_nxt = `HBL_WORD_ZERO;
      else
         dout_nxt = {csr_hi, csr_lo};
   end

   // Data reloaded every cycle while the read strobe stays asserted
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         dout_r <= `HBL_WORD_ZERO;
      else if (st_r == HBL_ST_BUSY && s_rd)
         dout_r <= dout_nxt;
   end

   assign host_data_lines_o      = dout_r;
   // Driven only while a selected read is in flight
   assign host_data_lines_oe_b_o = !(st_r == HBL_ST_BUSY && s_rd);

   // Window strobes: one pulse per access
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pdw_rd_o     <= 1'b0;
         pdw_wr_o     <= 1'b0;
         pdw_wdata_o  <= `HBL_WORD_ZERO;
         ctrl_reset_o <= 1'b0;
      end
      else
      begin
         pdw_rd_o     <= start_rd && is_win;
         pdw_wr_o     <= start_wr && is_win;
         pdw_wdata_o  <= s_data;
         ctrl_reset_o <= start_rd && (s_addr == `HBL_OFS_RESET);
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb_asrt @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_oe_only_read;
      !host_data_lines_oe_b_o |-> !s_cs_b && !s_rd_b && !$past(s_cs_b);
   endproperty
   a_oe_only_read: assert property (p_oe_only_read)
      else $error("data lanes driven outside a read");
   property p_reset_read;
      start_rd && s_addr == `HBL_OFS_RESET |=> ctrl_reset_o;
   endproperty
   a_reset_read: assert property (p_reset_read)
      else $error("read of reset offset gave no reset");
   property p_no_reset_write;
      ctrl_reset_o |-> $past(start_rd) && !$past(start_wr);
   endproperty
   a_no_reset_write: assert property (p_no_reset_write)
      else $error("reset pulse without a read");
   property p_mode_hold;
      strap_done_r && $past(strap_done_r) |-> $stable(mode_r);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("bus setting changed after capture");
   property p_isa_default;
      !strap_done_r && fill_r[1] && !s_clk |=> mode_r == HBL_MODE_ISA;
   endproperty
   a_isa_default: assert property (p_isa_default)
      else $error("ISA setting not chosen");
   property p_steer_sel;
      !strap_done_r && fill_r[1] && s_clk && !s_sel
         |=> mode_r == HBL_MODE_STEER;
   endproperty
   a_steer_sel: assert property (p_steer_sel)
      else $error("steered setting not chosen");
   property p_unused_nowrite;
      s_addr == `HBL_OFS_UNUSED || s_addr == `HBL_OFS_DATA_WINDOW |-> !wr_en;
   endproperty
   a_unused_nowrite: assert property (p_unused_nowrite)
      else $error("register write at non-register offset");
   property p_odd_steer_hi;
      wr_en && steer && s_addr[0] |-> wr_byte == s_data[15:8];
   endproperty
   a_odd_steer_hi: assert property (p_odd_steer_hi)
      else $error("odd steered write took the wrong lane");
   property p_isa_lo;
      wr_en && !steer |-> wr_byte == s_data[7:0];
   endproperty
   a_isa_lo: assert property (p_isa_lo)
      else $error("ISA write took the wrong lane");
   property p_win_wr;
      start_wr && is_win |=> pdw_wr_o ##1 !pdw_wr_o;
   endproperty
   a_win_wr: assert property (p_win_wr)
      else $error("window write strobe wrong");

   c_csr_read: cover property (@(posedge clk_i) start_rd && in_csr);
   c_steer_odd_wr: cover property (@(posedge clk_i) wr_en && steer
                                   && s_addr[0]);
   c_win_read: cover property (@(posedge clk_i) start_rd && is_win);
   c_reset: cover property (@(posedge clk_i) ctrl_reset_o);

endmodule

/* logic/hbl_regs.svh */
`ifndef HBL_REGS_SVH
`define HBL_REGS_SVH

// Host address decode points
`define HBL_OFS_DATA_WINDOW  6'h10
`define HBL_OFS_UNUSED       6'h11
`define HBL_OFS_LOW_ONLY     6'h1E
`define HBL_OFS_RESET        6'h1F
`define HBL_OFS_CSR_LAST     6'h1F
// Register file geometry
`define HBL_CSR_DEPTH        32
`define HBL_CSR_AW           5
// Reset value of the byte registers
`define HBL_CSR_RST          8'h00
// Zero lane value
`define HBL_LANE_ZERO        8'h00
// Zero word and zero address
`define HBL_WORD_ZERO        16'h0000
`define HBL_ADDR_ZERO        6'h00
// Synchroniser reset: strobes and select idle high, all else low
`define HBL_SYNC_IDLE        27'h0070000
// Strap settle shifter, empty after reset
`define HBL_FILL_EMPTY       2'b00

`endif

/* logic/hbl_pkg.sv */
package hbl_pkg;

   // Strap-selected host bus setting
   typedef enum logic [2:0]
   {
      HBL_MODE_ISA  = 3'b001,
      HBL_MODE_STEER = 3'b010,
      HBL_MODE_MCU  = 3'b100
   } hbl_mode_e;

   // Host access state
   typedef enum logic [1:0]
   {
      HBL_ST_IDLE = 2'b01,
      HBL_ST_BUSY = 2'b10
   } hbl_state_e;

endpackage

/* logic/hbl_csr_mem.sv */
`timescale 1ns/1ps
`include "hbl_regs.svh"

// Byte register file, two read ports (even/odd lane), registered read data
module hbl_csr_mem
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Write port
   input  wire logic       wr_en_i,
   input  wire logic [4:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   // Read ports
   input  wire logic [4:0] rd_addr_lo_i,
   input  wire logic [4:0] rd_addr_hi_i,
   output logic      [7:0] rd_data_lo_o,
   output logic      [7:0] rd_data_hi_o
);

   logic [7:0] mem_r [`HBL_CSR_DEPTH];
   logic [7:0] rd_lo_nxt;
   logic [7:0] rd_hi_nxt;

   // Read lookup
   always_comb
   begin
      rd_lo_nxt = mem_r[rd_addr_lo_i];
      rd_hi_nxt = mem_r[rd_addr_hi_i];
   end

   // One always block per entry keeps reset and write uniform
   for (genvar g = 0; g < `HBL_CSR_DEPTH; g++)
   begin : g_ent
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
            mem_r[g] <= `HBL_CSR_RST;
         else if (wr_en_i && wr_addr_i == 5'(g))
            mem_r[g] <= wr_data_i;
      end
   end

   // Registered read data
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_lo_o <= `HBL_LANE_ZERO;
         rd_data_hi_o <= `HBL_LANE_ZERO;
      end
      else
      begin
         rd_data_lo_o <= rd_lo_nxt;
         rd_data_hi_o <= rd_hi_nxt;
      end
   end

endmodule

/* test/hbl_host_model.sv */
`timescale 1ns/1ps

// Host processor model: one qualified access at a time
module hbl_host_model
(
   // Clock
   input  wire logic        clk_i,
   // Device side of the data lanes
   input  wire logic [15:0] dev_data_i,
   input  wire logic        dev_oe_b_i,
   // Host bus pins
   output logic      [5:0]  host_addr_o,
   output logic             host_cs_b_o,
   output logic             host_rd_b_o,
   output logic             host_wr_b_o,
   output logic      [15:0] host_drv_o
);

   // Idle bus: nothing selected
   initial
   begin
      host_addr_o = 6'h00;
      host_cs_b_o = 1'b1;
      host_rd_b_o = 1'b1;
      host_wr_b_o = 1'b1;
      host_drv_o  = 16'h0000;
   end

   // Strobe held 6 clocks, released lanes show the inverse
   task automatic acc(input logic wr, input logic [5:0] a,
                      input logic [15:0] d, output logic [15:0] q,
                      output logic [1:0] oe);
      @(posedge clk_i);
      #1;
      host_addr_o = a;
      host_drv_o  = d;
      host_cs_b_o = 1'b0;
      host_rd_b_o = wr;
      host_wr_b_o = !wr;
      repeat (6) @(posedge clk_i);
      q     = dev_data_i;
      oe[1] = dev_oe_b_i;
      #1;
      host_cs_b_o = 1'b1;
      host_rd_b_o = 1'b1;
      host_wr_b_o = 1'b1;
      host_drv_o  = ~d;
      // Gap above 3 clocks so the release is seen
      repeat (5) @(posedge clk_i);
      oe[0] = dev_oe_b_i;
   endtask

endmodule

/* test/tb.sv */
`timescale 1ns/1ps

module tb
   import hbl_pkg::*;
;
   logic        clk, rst_b, s_sel, s_clk;
   logic [15:0] pbuf, dout, drv, wcap;
   logic [5:0]  addr;
   logic        cs_b, rd_b, wr_b, oe_b, p_rd, p_wr, c_rst;
   logic [15:0] p_wd;
   hbl_mode_e   mode;
   logic [7:0]  sh [0:31];
   int          err_count, check_count, wcnt, rcnt, xcnt;
   wire  [15:0] lanes = !oe_b ? dout : drv;

   hbl_host_port i_hbl_host_port (.clk_i(clk), .rst_b_i(rst_b),
      .eeprom_select_strap_i(s_sel), .eeprom_clock_strap_i(s_clk),
      .host_addr_i(addr), .host_cs_b_i(cs_b), .host_rd_b_i(rd_b),
      .host_wr_b_i(wr_b), .host_data_lines_i(lanes),
      .host_data_lines_o(dout), .host_data_lines_oe_b_o(oe_b),
      .pdw_rd_o(p_rd), .pdw_wr_o(p_wr), .pdw_wdata_o(p_wd),
      .pdw_rdata_i(pbuf), .bus_mode_o(mode), .ctrl_reset_o(c_rst));

   hbl_host_model i_hbl_host_model (.clk_i(clk), .dev_data_i(dout),
      .dev_oe_b_i(oe_b), .host_addr_o(addr), .host_cs_b_o(cs_b),
      .host_rd_b_o(rd_b), .host_wr_b_o(wr_b), .host_drv_o(drv));

   // Clock and time-zero inputs
   initial
   begin
      clk   = 1'b0;
      rst_b = 1'b0;
      s_sel = 1'b0;
      s_clk = 1'b0;
      pbuf  = 16'hA55A;
      forever #12.5 clk = ~clk;
   end

   // Count one-cycle pulses the device raises
   always @(posedge clk)
   begin
      if (p_wr === 1'b1)
      begin
         wcnt++;
         wcap = p_wd;
      end
      if (p_rd === 1'b1) rcnt++;
      if (c_rst === 1'b1) xcnt++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic rd(input logic [5:0] a, output logic [15:0] q);
      logic [1:0] oe;
      i_hbl_host_model.acc(1'b0, a, 16'h0000, q, oe);
      chk({14'h0, oe}, 16'h0001);
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] q;
      logic [1:0]  oe;
      i_hbl_host_model.acc(1'b1, a, d, q, oe);
      chk({14'h0, oe}, 16'h0003);
   endtask

   // Reset with given straps, then flip straps: setting must hold
   task automatic do_reset(input logic sel, input logic ck);
      #1;
      rst_b = 1'b0;
      s_sel = sel;
      s_clk = ck;
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      s_sel = !sel;
      s_clk = !ck;
      repeat (4) @(posedge clk);
   endtask

   // Write every byte register, wanted byte opposite the other lane
   task automatic fill(input logic steer);
      logic [7:0] p;
      for (int o = 0; o < 32; o++)
      begin
         if (o == 16 || o == 17) continue;
         p     = 8'h40 + 8'(o * 3);
         sh[o] = p;
         if (steer && o[0]) wr(6'(o), {p, ~p});
         else wr(6'(o), {~p, p});
      end
   endtask

   task automatic verify(input logic steer);
      logic [15:0] q, e;
      for (int o = 0; o < 31; o++)
      begin
         if (o == 16 || o == 17) continue;
         rd(6'(o), q);
         if (o == 30) e = {8'h00, sh[30]};
         else if (!o[0]) e = {sh[o + 1], sh[o]};
         else if (steer) e = {sh[o], sh[o - 1]};
         else e = {sh[o], sh[o]};
         chk(q, e);
      end
   endtask

   task automatic t_isa();
      do_reset(1'b0, 1'b0);
      chk({13'h0, mode}, {13'h0, HBL_MODE_ISA});
      fill(1'b0);
      verify(1'b0);
   endtask

   task automatic t_window();
      logic [15:0] q;
      int w0, r0;
      w0 = wcnt;
      r0 = rcnt;
      wr(6'h10, 16'hBEEF);
      chk(16'(wcnt - w0), 16'h0001);
      chk(wcap, 16'hBEEF);
      rd(6'h10, q);
      chk(q, pbuf);
      chk(16'(rcnt - r0), 16'h0001);
      wr(6'h11, 16'h1234);
      rd(6'h11, q);
      chk(q, 16'h0000);
      chk(16'(wcnt - w0), 16'h0001);
      chk(16'(rcnt - r0), 16'h0001);
   endtask

   task automatic t_reset_read();
      logic [15:0] q;
      int x0;
      x0 = xcnt;
      wr(6'h1F, 16'h00C3);
      chk(16'(xcnt - x0), 16'h0000);
      rd(6'h1F, q);
      chk(16'(xcnt - x0), 16'h0001);
   endtask

   task automatic t_steer();
      do_reset(1'b0, 1'b1);
      chk({13'h0, mode}, {13'h0, HBL_MODE_STEER});
      fill(1'b1);
      verify(1'b1);
      t_window();
   endtask

   task automatic t_mcu();
      do_reset(1'b1, 1'b1);
      chk({13'h0, mode}, {13'h0, HBL_MODE_MCU});
   endtask

   // Main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      t_isa();
      t_window();
      t_reset_read();
      t_steer();
      t_mcu();
      summarize();
   end

   // Hang guard
   initial
   begin
      repeat (90000) @(posedge clk);
      err_count++;
      summarize();
   end

endmodule
